// [rtl/pbcg_clk_gate.sv]
module pbcg_clk_gate #(
    parameter int N = 9
) (
    // Bus clock
    input wire logic aclk,
    // Enables in, gated clocks out
    pbcg_gate_if.gate g
);

    logic [N-1:0] en_lo_r;
    logic [N-1:0] en_lo_nxt;

    always_comb
    begin
        en_lo_nxt = g.en;
    end

    // Enable moves only while the clock is low, so no runt pulses
    always_ff @(negedge aclk)
    begin
        en_lo_r <= en_lo_nxt;
    end

    assign g.gclk = {N{aclk}} & en_lo_r;

endmodule // pbcg_clk_gate

// [rtl/pbcg_gate_if.sv]
interface pbcg_gate_if #(
    parameter int N = 9
);
    logic [N-1:0] en;
    logic [N-1:0] gclk;

    modport ctrl (
        output en,
        input gclk
    );
    modport gate (
        input en,
        output gclk
    );
endinterface // pbcg_gate_if

// [rtl/pbcg_pkg.sv]
package pbcg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map: word indices, byte address is four times the index
    localparam int ADDR_W = 16;
    localparam logic [13:0] SERIAL_GATE_IDX = 14'h300E;
    localparam logic [13:0] ANALOG_GATE_IDX = 14'h300F;

    ////////////////////////////////////////////////////////////////////////
    // Serial peripheral gate fields
    localparam int SER_SECOND_ASYNC_BIT = 5;
    localparam int SER_FIRST_ASYNC_BIT = 4;
    localparam int SER_SYNC_SERIAL_BIT = 2;
    localparam int SER_TWO_WIRE_BIT = 1;
    localparam logic [7:0] SERIAL_GATE_MASK = 8'h36;
    localparam logic [7:0] SERIAL_GATE_RESET = 8'h36;

    ////////////////////////////////////////////////////////////////////////
    // Analog and input gate fields
    localparam int ANA_COMPARATOR_BIT = 7;
    localparam int ANA_CONVERTER_BIT = 5;
    localparam int ANA_EXT_IRQ_BIT = 3;
    localparam int ANA_TOUCH_BIT = 2;
    localparam int ANA_KEYBOARD_BIT = 0;
    localparam logic [7:0] ANALOG_GATE_MASK = 8'hAD;
    localparam logic [7:0] ANALOG_GATE_RESET = 8'hAD;

    ////////////////////////////////////////////////////////////////////////
    // Bus answers and gated clock count
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int GATE_COUNT = 9;

    typedef enum logic [1:0] {
        PBCG_SEL_NONE = 2'b00,
        PBCG_SEL_SERIAL = 2'b01,
        PBCG_SEL_ANALOG = 2'b10
    } pbcg_sel_type;

    function automatic pbcg_sel_type pbcg_decode(
        input logic [ADDR_W-1:0] addr
    );
        pbcg_sel_type sel;
        sel = PBCG_SEL_NONE;
        if (addr[ADDR_W-1:2] == SERIAL_GATE_IDX)
        begin
            sel = PBCG_SEL_SERIAL;
        end
        else if (addr[ADDR_W-1:2] == ANALOG_GATE_IDX)
        begin
            sel = PBCG_SEL_ANALOG;
        end
        return sel;
    endfunction

endpackage

// [rtl/pbcg_reg8.sv]
module pbcg_reg8 #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hFF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write strobe and data
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    // Stored value
    output logic [7:0] q
);

    logic [7:0] q_r;
    logic [7:0] q_nxt;

    // Reserved bits stay zero, writes to them are dropped
    always_comb
    begin
        q_nxt = q_r;
        if (wr_en)
        begin
            q_nxt = wdata & WR_MASK;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q_r <= RESET_VAL & WR_MASK;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule // pbcg_reg8

// [rtl/pbcg_top.sv]
module pbcg_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [pbcg_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [pbcg_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Gate enables, registered
    output logic [7:0] serial_gate_en,
    output logic [7:0] analog_gate_en,
    // Gated peripheral bus clocks
    output logic clk_second_async_serial_port,
    output logic clk_first_async_serial_port,
    output logic clk_synchronous_serial_port,
    output logic clk_two_wire_port,
    output logic clk_analog_comparator,
    output logic clk_converter,
    output logic clk_ext_irq_pin,
    output logic clk_touch_sensing_input,
    output logic clk_keyboard_interrupt_unit
);

    ////////////////////////////////////////////////////////////////////////
    // Write channel state
    typedef enum logic [1:0] {
        PBCG_WR_COLLECT = 2'b00,
        PBCG_WR_RESP = 2'b01
    } pbcg_wr_state_type;

    pbcg_wr_state_type wr_state_r;
    pbcg_wr_state_type wr_state_nxt;
    logic awready_r;
    logic awready_nxt;
    logic wready_r;
    logic wready_nxt;
    logic aw_have_r;
    logic aw_have_nxt;
    logic w_have_r;
    logic w_have_nxt;
    logic [pbcg_pkg::ADDR_W-1:0] awaddr_r;
    logic [pbcg_pkg::ADDR_W-1:0] awaddr_nxt;
    logic [7:0] wbyte_r;
    logic [7:0] wbyte_nxt;
    logic wlane_r;
    logic wlane_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;

    logic aw_fire;
    logic w_fire;
    logic wr_go;
    logic [pbcg_pkg::ADDR_W-1:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane;
    pbcg_pkg::pbcg_sel_type wr_sel;
    logic wr_serial;
    logic wr_analog;

    ////////////////////////////////////////////////////////////////////////
    // Read channel state
    typedef enum logic [1:0] {
        PBCG_RD_IDLE = 2'b00,
        PBCG_RD_DATA = 2'b01
    } pbcg_rd_state_type;

    pbcg_rd_state_type rd_state_r;
    pbcg_rd_state_type rd_state_nxt;
    logic arready_r;
    logic arready_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    pbcg_pkg::pbcg_sel_type rd_sel;

    logic [7:0] serial_q;
    logic [7:0] analog_q;

    ////////////////////////////////////////////////////////////////////////
    // Write path: address and data taken in either order
    assign aw_fire = s_axi_awvalid & awready_r;
    assign w_fire = s_axi_wvalid & wready_r;
    assign wr_addr = aw_have_r ? awaddr_r : s_axi_awaddr;
    assign wr_byte = w_have_r ? wbyte_r : s_axi_wdata[7:0];
    assign wr_lane = w_have_r ? wlane_r : s_axi_wstrb[0];
    assign wr_go = (wr_state_r == PBCG_WR_COLLECT)
        && (aw_have_r || aw_fire) && (w_have_r || w_fire);
    assign wr_sel = pbcg_pkg::pbcg_decode(wr_addr);
    assign wr_serial = wr_go && wr_lane
        && (wr_sel == pbcg_pkg::PBCG_SEL_SERIAL);
    assign wr_analog = wr_go && wr_lane
        && (wr_sel == pbcg_pkg::PBCG_SEL_ANALOG);

    always_comb
    begin
        wr_state_nxt = wr_state_r;
        awready_nxt = awready_r;
        wready_nxt = wready_r;
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        awaddr_nxt = awaddr_r;
        wbyte_nxt = wbyte_r;
        wlane_nxt = wlane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        unique case (wr_state_r)
            PBCG_WR_COLLECT:
            begin
                if (aw_fire)
                begin
                    aw_have_nxt = 1'b1;
                    awaddr_nxt = s_axi_awaddr;
                end
                if (w_fire)
                begin
                    w_have_nxt = 1'b1;
                    wbyte_nxt = s_axi_wdata[7:0];
                    wlane_nxt = s_axi_wstrb[0];
                end
                awready_nxt = !(aw_have_r || aw_fire);
                wready_nxt = !(w_have_r || w_fire);
                if (wr_go)
                begin
                    wr_state_nxt = PBCG_WR_RESP;
                    awready_nxt = 1'b0;
                    wready_nxt = 1'b0;
                    aw_have_nxt = 1'b0;
                    w_have_nxt = 1'b0;
                    bvalid_nxt = 1'b1;
                    if (wr_sel == pbcg_pkg::PBCG_SEL_NONE)
                    begin
                        bresp_nxt = pbcg_pkg::RESP_SLVERR;
                    end
                    else
                    begin
                        bresp_nxt = pbcg_pkg::RESP_OKAY;
                    end
                end
            end
            PBCG_WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    wr_state_nxt = PBCG_WR_COLLECT;
                    bvalid_nxt = 1'b0;
                    awready_nxt = 1'b1;
                    wready_nxt = 1'b1;
                end
            end
            default:
            begin
                wr_state_nxt = PBCG_WR_COLLECT;
                bvalid_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_r <= PBCG_WR_COLLECT;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 16'h0000;
            wbyte_r <= 8'h00;
            wlane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= pbcg_pkg::RESP_OKAY;
        end
        else
        begin
            wr_state_r <= wr_state_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            awaddr_r <= awaddr_nxt;
            wbyte_r <= wbyte_nxt;
            wlane_r <= wlane_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path
    assign rd_sel = pbcg_pkg::pbcg_decode(s_axi_araddr);

    always_comb
    begin
        rd_state_nxt = rd_state_r;
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        unique case (rd_state_r)
            PBCG_RD_IDLE:
            begin
                arready_nxt = 1'b1;
                if (s_axi_arvalid && arready_r)
                begin
                    rd_state_nxt = PBCG_RD_DATA;
                    arready_nxt = 1'b0;
                    rvalid_nxt = 1'b1;
                    rresp_nxt = pbcg_pkg::RESP_OKAY;
                    unique case (rd_sel)
                        pbcg_pkg::PBCG_SEL_SERIAL:
                            rdata_nxt = {24'h00_0000, serial_q};
                        pbcg_pkg::PBCG_SEL_ANALOG:
                            rdata_nxt = {24'h00_0000, analog_q};
                        default:
                        begin
                            rdata_nxt = 32'h0000_0000;
                            rresp_nxt = pbcg_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            PBCG_RD_DATA:
            begin
                if (s_axi_rready)
                begin
                    rd_state_nxt = PBCG_RD_IDLE;
                    rvalid_nxt = 1'b0;
                    arready_nxt = 1'b1;
                end
            end
            default:
            begin
                rd_state_nxt = PBCG_RD_IDLE;
                rvalid_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_state_r <= PBCG_RD_IDLE;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= pbcg_pkg::RESP_OKAY;
        end
        else
        begin
            rd_state_r <= rd_state_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gating registers
    pbcg_reg8 #(
        .RESET_VAL(pbcg_pkg::SERIAL_GATE_RESET),
        .WR_MASK(pbcg_pkg::SERIAL_GATE_MASK)
    ) u_serial_gate (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_serial),
        .wdata(wr_byte),
        .q(serial_q)
    );

    pbcg_reg8 #(
        .RESET_VAL(pbcg_pkg::ANALOG_GATE_RESET),
        .WR_MASK(pbcg_pkg::ANALOG_GATE_MASK)
    ) u_analog_gate (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_analog),
        .wdata(wr_byte),
        .q(analog_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Glitch-free clock gates
    pbcg_gate_if #(.N(pbcg_pkg::GATE_COUNT)) gates ();

    assign gates.en[0] = serial_q[pbcg_pkg::SER_SECOND_ASYNC_BIT];
    assign gates.en[1] = serial_q[pbcg_pkg::SER_FIRST_ASYNC_BIT];
    assign gates.en[2] = serial_q[pbcg_pkg::SER_SYNC_SERIAL_BIT];
    assign gates.en[3] = serial_q[pbcg_pkg::SER_TWO_WIRE_BIT];
    assign gates.en[4] = analog_q[pbcg_pkg::ANA_COMPARATOR_BIT];
    assign gates.en[5] = analog_q[pbcg_pkg::ANA_CONVERTER_BIT];
    assign gates.en[6] = analog_q[pbcg_pkg::ANA_EXT_IRQ_BIT];
    assign gates.en[7] = analog_q[pbcg_pkg::ANA_TOUCH_BIT];
    assign gates.en[8] = analog_q[pbcg_pkg::ANA_KEYBOARD_BIT];

    pbcg_clk_gate #(
        .N(pbcg_pkg::GATE_COUNT)
    ) u_clk_gate (
        .aclk(aclk),
        .g(gates.gate)
    );

    assign clk_second_async_serial_port = gates.gclk[0];
    assign clk_first_async_serial_port = gates.gclk[1];
    assign clk_synchronous_serial_port = gates.gclk[2];
    assign clk_two_wire_port = gates.gclk[3];
    assign clk_analog_comparator = gates.gclk[4];
    assign clk_converter = gates.gclk[5];
    assign clk_ext_irq_pin = gates.gclk[6];
    assign clk_touch_sensing_input = gates.gclk[7];
    assign clk_keyboard_interrupt_unit = gates.gclk[8];

    ////////////////////////////////////////////////////////////////////////
    // Output mapping
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign serial_gate_en = serial_q;
    assign analog_gate_en = analog_q;

endmodule // pbcg_top

// [tb/pbcg_top_asserts.sv]
module pbcg_top_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic [pbcg_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [pbcg_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    // Gate state and clocks
    input wire logic [7:0] serial_gate_en,
    input wire logic [7:0] analog_gate_en,
    input wire logic clk_second_async_serial_port,
    input wire logic clk_first_async_serial_port,
    input wire logic clk_synchronous_serial_port,
    input wire logic clk_two_wire_port,
    input wire logic clk_analog_comparator,
    input wire logic clk_converter,
    input wire logic clk_ext_irq_pin,
    input wire logic clk_touch_sensing_input,
    input wire logic clk_keyboard_interrupt_unit
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic [7:0] ser_seen_r;
    logic [7:0] ana_seen_r;
    logic [8:0] gclk;

    assign gclk = {clk_second_async_serial_port, clk_first_async_serial_port,
        clk_synchronous_serial_port, clk_two_wire_port, clk_analog_comparator,
        clk_converter, clk_ext_irq_pin, clk_touch_sensing_input,
        clk_keyboard_interrupt_unit};

    // Enables as the gate latches hold them in the high phase
    always_ff @(negedge aclk)
    begin
        ser_seen_r <= serial_gate_en;
        ana_seen_r <= analog_gate_en;
    end

    sequence wr_hit_s(idx);
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_wstrb[0] && s_axi_awaddr[15:2] == idx;
    endsequence

    sequence rd_hit_s(idx);
        s_axi_arvalid && s_axi_arready && s_axi_araddr[15:2] == idx;
    endsequence

    reset_val_a: assert property ($rose(aresetn) |->
        serial_gate_en == 8'h36 && analog_gate_en == 8'hAD)
        else $error("gate registers not at reset value");
    rsvd_zero_a: assert property (
        ((serial_gate_en & 8'hC9) | (analog_gate_en & 8'h52)) == 8'h00)
        else $error("reserved gate bit set");
    serial_wr_a: assert property (wr_hit_s(14'h300E) |=>
        {24'h00_0000, serial_gate_en} == ($past(s_axi_wdata) & 32'h0000_0036))
        else $error("serial gate write not applied");
    analog_wr_a: assert property (wr_hit_s(14'h300F) |=>
        {24'h00_0000, analog_gate_en} == ($past(s_axi_wdata) & 32'h0000_00AD))
        else $error("analog gate write not applied");
    serial_rd_a: assert property (rd_hit_s(14'h300E) |=>
        s_axi_rdata == {24'h00_0000, $past(serial_gate_en)})
        else $error("serial gate read wrong");
    analog_rd_a: assert property (rd_hit_s(14'h300F) |=>
        s_axi_rdata == {24'h00_0000, $past(analog_gate_en)})
        else $error("analog gate read wrong");
    en_hold_a: assert property ($changed(serial_gate_en)
        || $changed(analog_gate_en) |-> $rose(s_axi_bvalid))
        else $error("gate enable changed without a write");
    serial_clk_a: assert property (
        @(negedge aclk) disable iff (!aresetn)
        gclk[8:5] == {ser_seen_r[5], ser_seen_r[4], ser_seen_r[2],
        ser_seen_r[1]}) else $error("serial gated clock wrong");
    analog_clk_a: assert property (
        @(negedge aclk) disable iff (!aresetn)
        gclk[4:0] == {ana_seen_r[7], ana_seen_r[5], ana_seen_r[3],
        ana_seen_r[2], ana_seen_r[0]})
        else $error("analog gated clock wrong");
    clk_low_a: assert property (gclk == 9'h000)
        else $error("gated clock high while bus clock low");
endmodule // pbcg_top_asserts

bind pbcg_top pbcg_top_asserts i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .serial_gate_en(serial_gate_en),
    .analog_gate_en(analog_gate_en),
    .clk_second_async_serial_port(clk_second_async_serial_port),
    .clk_first_async_serial_port(clk_first_async_serial_port),
    .clk_synchronous_serial_port(clk_synchronous_serial_port),
    .clk_two_wire_port(clk_two_wire_port),
    .clk_analog_comparator(clk_analog_comparator),
    .clk_converter(clk_converter), .clk_ext_irq_pin(clk_ext_irq_pin),
    .clk_touch_sensing_input(clk_touch_sensing_input),
    .clk_keyboard_interrupt_unit(clk_keyboard_interrupt_unit));

// [tb/pbcg_top_tb.sv]
module pbcg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Word index 300E and 300F, times four
    localparam logic [15:0] SER_A = 16'hC038;
    localparam logic [15:0] ANA_A = 16'hC03C;
    localparam logic [15:0] HOLE_A = 16'hC030;

    logic aclk;
    logic aresetn;
    logic [15:0] awaddr;
    logic [15:0] araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] ser_en;
    logic [7:0] ana_en;
    wire [8:0] gclk;
    int num_errors = 0;
    int checks_done = 0;

    pbcg_top i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_gate_en(ser_en), .analog_gate_en(ana_en),
        .clk_second_async_serial_port(gclk[8]),
        .clk_first_async_serial_port(gclk[7]),
        .clk_synchronous_serial_port(gclk[6]),
        .clk_two_wire_port(gclk[5]), .clk_analog_comparator(gclk[4]),
        .clk_converter(gclk[3]), .clk_ext_irq_pin(gclk[2]),
        .clk_touch_sensing_input(gclk[1]),
        .clk_keyboard_interrupt_unit(gclk[0]));

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic guard(input int n);
        if (n >= 64)
        begin
            num_errors++;
            $display("Error at %0t: bus wait ran out", $time);
            summarize();
        end
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d,
        input logic [3:0] s, output logic [1:0] resp);
        int n;
        logic aw_ok;
        logic w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok) && n < 64)
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        guard(n);
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (bvalid !== 1'b1 && n < 64);
        resp = bresp;
        bready <= 1'b0;
        guard(n);
    endtask

    task automatic bus_rd(input logic [15:0] a, output logic [31:0] d,
        output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (arready !== 1'b1 && n < 64);
        arvalid <= 1'b0;
        guard(n);
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (rvalid !== 1'b1 && n < 64);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        guard(n);
    endtask

    // Gated clocks seen in the high phase, then both registers read back
    task automatic expect_state(input logic [7:0] s, input logic [7:0] a);
        logic [31:0] d;
        logic [1:0] r;
        logic [3:0] gs;
        logic [4:0] ga;
        gs = {s[5], s[4], s[2], s[1]};
        ga = {a[7], a[5], a[3], a[2], a[0]};
        @(posedge aclk);
        #1;
        check(32'(gclk[8:5]), 32'(gs));
        check(32'(gclk[4:0]), 32'(ga));
        check({16'h0000, ser_en, ana_en}, {16'h0000, s, a});
        bus_rd(SER_A, d, r);
        check({d[29:0], r}, {22'h00_0000, s, 2'b00});
        bus_rd(ANA_A, d, r);
        check({d[29:0], r}, {22'h00_0000, a, 2'b00});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic apply_reset();
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        expect_state(8'h36, 8'hAD);
        $display("reset values done");
    endtask

    task automatic test_fields();
        logic [7:0] v;
        logic [7:0] s;
        logic [7:0] a;
        logic [1:0] r;
        s = 8'h36;
        a = 8'hAD;
        // No peripheral runs here, so gating off needs no disable
        for (int k = 0; k < 2; k++)
        begin
            for (int i = 0; i < 10; i++)
            begin
                v = (i < 8) ? (8'h01 << i) : ((i == 8) ? 8'hFF : 8'h00);
                bus_wr(k ? ANA_A : SER_A, v, 4'h1, r);
                check(32'(r), 32'h0000_0000);
                s = k ? s : (v & 8'h36);
                a = k ? (v & 8'hAD) : a;
                expect_state(s, a);
            end
        end
        $display("field walk done");
    endtask

    task automatic test_refused();
        logic [31:0] d;
        logic [1:0] r;
        bus_wr(SER_A, 8'hFF, 4'hE, r);
        check(32'(r), 32'h0000_0000);
        bus_wr(HOLE_A, 8'hFF, 4'hF, r);
        check(32'(r), 32'h0000_0002);
        bus_rd(HOLE_A, d, r);
        check({d[29:0], r}, 32'h0000_0002);
        expect_state(8'h00, 8'h00);
        bus_wr(SER_A, 8'h12, 4'h1, r);
        bus_wr(ANA_A, 8'h81, 4'h1, r);
        expect_state(8'h12, 8'h81);
        $display("refused writes done");
    endtask

    initial
    begin
        aresetn = 1'b0;
        awaddr = 16'h0000;
        araddr = 16'h0000;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        apply_reset();
        test_fields();
        test_refused();
        apply_reset();
        summarize();
    end
endmodule // pbcg_top_tb
